// >>> verilog/psfm_pkg.sv
package psfm_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned CLK_PERIOD_PS   = 25_000;

    // Times in nanoseconds
    localparam int unsigned BST_ARM_NS      = 20_000;
    localparam int unsigned UV_RECOVER_NS   = 37_000;

    // Cycle counts derived from times (both rounded up, so each is a least time)
    localparam int unsigned BST_ARM_CYC     = (BST_ARM_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam int unsigned UV_RECOVER_CYC  = (UV_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam int unsigned CNT_W           = 11;

    // Three-state PWM input encoding
    typedef enum logic [1:0] {
        PSFM_PWM_LOW  = 2'b00,
        PSFM_PWM_HIGH = 2'b01,
        PSFM_PWM_TRI  = 2'b10
    } psfm_pwm_e;

    // Fault condition inputs, each high while the condition is present
    typedef struct packed {
        logic control_supply_undervoltage_lock;
        logic boost_undervoltage_lock;
        logic input_undervoltage_lock;
        logic over_temperature;
        logic switching_node_short;
        logic sourcing_current_limit;
        logic sinking_current_limit;
    } psfm_fault_in_s;

    // Gate drive outputs
    typedef struct packed {
        logic high_side_on;
        logic low_side_on;
    } psfm_drive_s;

    // Reset values
    localparam logic                 LATCH_RST = 1'b0;
    localparam logic [CNT_W-1:0]     CNT_RST   = 11'h000;

endpackage

// >>> verilog/psfm_sync.sv
`timescale 1ns/1ps
module psfm_sync #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } psfm_sync_s;

    psfm_sync_s st_q;
    psfm_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule // psfm_sync

// >>> verilog/psfm_fault_mgr.sv
`timescale 1ns/1ps
module psfm_fault_mgr #(
    parameter int unsigned ARM_CYC     = psfm_pkg::BST_ARM_CYC,
    parameter int unsigned RECOVER_CYC = psfm_pkg::UV_RECOVER_CYC
) (
    // Clock and reset
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     RST_I,
    // Controller side
    input  wire psfm_pkg::psfm_pwm_e      PWM_STATE_I,
    input  wire logic                     REGULATION_EN_I,
    // Analog comparator pins
    input  wire psfm_pkg::psfm_fault_in_s FAULT_IN_I,
    // Switch drive
    output psfm_pkg::psfm_drive_s         DRIVE_O,
    // Temperature and fault line, shutdown and latched status
    output logic                          TEMP_AND_FAULT_LINE_FORCE_LOW_O,
    output logic                          TEMP_AND_FAULT_LINE_ANALOG_EN_O,
    output logic                          SHUTDOWN_O,
    output logic                          LATCHED_O
);
    import psfm_pkg::*;

    localparam int unsigned IN_W = $bits(psfm_fault_in_s) + 3;

    typedef struct packed {
        logic             armed;
        logic [CNT_W-1:0] arm_cnt;
        logic             uv_hold;
        logic [CNT_W-1:0] rec_cnt;
        logic             latched;
        logic             hs_trunc;
        logic             ls_trunc;
        logic             prev_high;
        psfm_drive_s      drive;
        logic             line_low;
    } psfm_state_s;

    psfm_state_s    st_q;
    psfm_state_s    st_d;
    logic [IN_W-1:0] raw;
    logic [IN_W-1:0] syn;
    psfm_fault_in_s  flt;
    psfm_pwm_e       pwm;
    logic            reg_en;
    logic            uv_now;
    logic            shut;
    logic            switching;

    assign raw = {FAULT_IN_I, PWM_STATE_I, REGULATION_EN_I};

    psfm_sync #(
        .W (IN_W)
    ) u_sync (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .d_i   (raw),
        .q_o   (syn)
    );

    assign flt    = psfm_fault_in_s'(syn[IN_W-1:3]);
    assign pwm    = psfm_pwm_e'(syn[2:1]);
    assign reg_en = syn[0];

    always_comb begin
        st_d      = st_q;
        switching = st_q.drive.high_side_on | st_q.drive.low_side_on;
        // Arming of boost supervision after startup
        if (!st_q.armed && reg_en) begin
            if (st_q.arm_cnt >= CNT_W'(ARM_CYC - 1)) begin
                st_d.armed = 1'b1;
            end else begin
                st_d.arm_cnt = st_q.arm_cnt + 1'b1;
            end
        end
        uv_now = flt.control_supply_undervoltage_lock
               | (flt.boost_undervoltage_lock & st_q.armed)
               | flt.input_undervoltage_lock;
        // Non-latching undervoltage with recovery delay
        if (uv_now) begin
            st_d.uv_hold = 1'b1;
            st_d.rec_cnt = CNT_RST;
        end else if (st_q.uv_hold) begin
            if (st_q.rec_cnt >= CNT_W'(RECOVER_CYC - 1)) begin
                st_d.uv_hold = 1'b0;
                st_d.rec_cnt = CNT_RST;
            end else begin
                st_d.rec_cnt = st_q.rec_cnt + 1'b1;
            end
        end
        // Latching faults cleared only by reset (power cycle)
        if (flt.over_temperature || (flt.switching_node_short && switching)) begin
            st_d.latched = 1'b1;
        end
        shut = st_d.uv_hold | st_d.latched;
        // Cycle-by-cycle limits, rearmed at each new PWM period
        st_d.prev_high = (pwm == PSFM_PWM_HIGH);
        if (pwm == PSFM_PWM_HIGH && !st_q.prev_high) begin
            st_d.hs_trunc = 1'b0;
            st_d.ls_trunc = 1'b0;
        end
        if (flt.sourcing_current_limit && pwm == PSFM_PWM_HIGH) begin
            st_d.hs_trunc = 1'b1;
        end
        if (flt.sinking_current_limit && pwm == PSFM_PWM_LOW) begin
            st_d.ls_trunc = 1'b1;
        end
        // Drive decode of the three-state input
        case (pwm)
            PSFM_PWM_HIGH: begin
                st_d.drive.high_side_on = ~st_d.hs_trunc;
                st_d.drive.low_side_on  = st_d.hs_trunc;
            end
            PSFM_PWM_LOW: begin
                st_d.drive.high_side_on = 1'b0;
                st_d.drive.low_side_on  = ~st_d.ls_trunc;
            end
            PSFM_PWM_TRI: begin
                st_d.drive = '0;
            end
            default: begin
                st_d.drive = '0;
            end
        endcase
        if (shut) begin
            st_d.drive = '0;
        end
        st_d.line_low = shut;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            st_q         <= '0;
            st_q.latched <= LATCH_RST;
            st_q.arm_cnt <= CNT_RST;
            st_q.rec_cnt <= CNT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign DRIVE_O                         = st_q.drive;
    assign TEMP_AND_FAULT_LINE_FORCE_LOW_O = st_q.line_low;
    assign TEMP_AND_FAULT_LINE_ANALOG_EN_O = ~st_q.line_low;
    assign SHUTDOWN_O                      = st_q.line_low;
    assign LATCHED_O                       = st_q.latched;
endmodule // psfm_fault_mgr

// >>> dv/psfm_fault_mgr_sva.sv
`timescale 1ns/1ps
module psfm_sva #(
    parameter int unsigned ARM_CYC     = 4,
    parameter int unsigned RECOVER_CYC = 6
) (
    input wire logic                     CORE_CLK_I,
    input wire logic                     RST_I,
    input wire psfm_pkg::psfm_fault_in_s FAULT_IN_I,
    input wire psfm_pkg::psfm_pwm_e      PWM_STATE_I,
    input wire psfm_pkg::psfm_drive_s    DRIVE_O,
    input wire logic                     TEMP_AND_FAULT_LINE_FORCE_LOW_O,
    input wire logic                     TEMP_AND_FAULT_LINE_ANALOG_EN_O,
    input wire logic                     SHUTDOWN_O,
    input wire logic                     LATCHED_O
);
    import psfm_pkg::*;
    // Shutdown-class fault inputs at the pins
    logic [4:0]  hard_flt;
    // Cycles since all undervoltage inputs went clear
    logic [11:0] clean_q;
    assign hard_flt = FAULT_IN_I[6:2];
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || FAULT_IN_I[6:4] != 3'h0) clean_q <= 12'h000;
        else if (clean_q != 12'hFFF) clean_q <= clean_q + 12'h001;
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    AST_LINE_EQ: assert property ($rose(TEMP_AND_FAULT_LINE_FORCE_LOW_O) |-> $past(hard_flt, 3) != 5'h00)
        else $error("line pulled low without fault");
    AST_ANALOG: assert property (LATCHED_O |-> !TEMP_AND_FAULT_LINE_ANALOG_EN_O)
        else $error("analog enable wrong");
    AST_OFF: assert property (SHUTDOWN_O |-> DRIVE_O == '0)
        else $error("switch on in shutdown");
    AST_OT: assert property ($rose(FAULT_IN_I.over_temperature) |-> ##[1:4] LATCHED_O)
        else $error("over temperature not latched");
    AST_HOLD: assert property (LATCHED_O |=> LATCHED_O && SHUTDOWN_O)
        else $error("latched fault dropped");
    AST_UV: assert property ($rose(FAULT_IN_I[6] | FAULT_IN_I[4]) |-> ##[1:4] SHUTDOWN_O)
        else $error("undervoltage ignored");
    AST_LIMIT: assert property ((hard_flt == 5'h00 && !SHUTDOWN_O) [*5] |=> !SHUTDOWN_O)
        else $error("shutdown without fault");
    AST_RECOVER: assert property ($fell(SHUTDOWN_O) |-> clean_q >= RECOVER_CYC)
        else $error("recovery too early");
    AST_TRI: assert property ((PWM_STATE_I == PSFM_PWM_TRI) [*4] |=> DRIVE_O == '0)
        else $error("switch on in three state");
    cover property ($rose(LATCHED_O));
    cover property ($fell(SHUTDOWN_O));
    cover property (FAULT_IN_I.sourcing_current_limit && DRIVE_O != '0);
endmodule // psfm_sva
bind psfm_fault_mgr psfm_sva #(.ARM_CYC(ARM_CYC), .RECOVER_CYC(RECOVER_CYC)) u_psfm_sva (
    .CORE_CLK_I, .RST_I, .FAULT_IN_I, .PWM_STATE_I, .DRIVE_O, .TEMP_AND_FAULT_LINE_FORCE_LOW_O,
    .TEMP_AND_FAULT_LINE_ANALOG_EN_O, .SHUTDOWN_O, .LATCHED_O);

// >>> dv/psfm_ctrl_model.sv
`timescale 1ns/1ps
module psfm_ctrl_model (
    input  wire logic [1:0]     mode_i,
    input  wire logic           clk_i,
    output psfm_pkg::psfm_pwm_e pwm_o
);
    import psfm_pkg::*;
    logic [2:0] ph_q = 3'h0;
    initial pwm_o = PSFM_PWM_TRI;
    // Mode 0 low, 1 switching, 2 phase shed
    always @(posedge clk_i) begin
        ph_q <= ph_q + 3'h1;
        pwm_o <= #2 (mode_i == 2'h2) ? PSFM_PWM_TRI :
            ((mode_i == 2'h1 && ph_q < 3'h3) ? PSFM_PWM_HIGH : PSFM_PWM_LOW);
    end
endmodule // psfm_ctrl_model

// >>> dv/test_power_stage_fault_manager.sv
`timescale 1ns/1ps
module test_power_stage_fault_manager;
    import psfm_pkg::*;
    localparam int REC = 6;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           reg_en = 1'b0;
    logic [1:0]     mode = 2'h2;
    psfm_fault_in_s fin = '0;
    psfm_pwm_e      pwm;
    psfm_drive_s    drv;
    logic           fl, aen, sd, lat;
    int             errors = 0;
    int             compares = 0;
    always #12.5 clk = ~clk;
    psfm_ctrl_model u_psfm_ctrl_model (.mode_i(mode), .clk_i(clk), .pwm_o(pwm));
    psfm_fault_mgr #(.ARM_CYC(4), .RECOVER_CYC(REC)) u_psfm_fault_mgr (
        .CORE_CLK_I(clk), .RST_I(rst), .PWM_STATE_I(pwm), .REGULATION_EN_I(reg_en),
        .FAULT_IN_I(fin), .DRIVE_O(drv), .TEMP_AND_FAULT_LINE_FORCE_LOW_O(fl),
        .TEMP_AND_FAULT_LINE_ANALOG_EN_O(aen), .SHUTDOWN_O(sd), .LATCHED_O(lat));
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Status is {line low, shutdown, analog, latched, any switch on}
    task automatic chk(input string n, input logic [4:0] e);
        logic [4:0] g;
        g = {fl, sd, aen, lat, |drv};
        compares++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Drive pair is {high side, low side}
    task automatic chk_drv(input string n, input logic [1:0] e, input logic [1:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic t_uv(input int b);
        mode = 2'h1;
        fin[b] = 1'b1;
        w(5);
        chk("uv shut", 5'h18);
        fin[b] = 1'b0;
        w(REC);
        chk("uv hold", 5'h18);
        mode = 2'h2;
        w(10);
        chk("uv free", 5'h04);
        $display("uv test %0d done", b);
    endtask
    task automatic t_arm;
        fin.boost_undervoltage_lock = 1'b1;
        w(8);
        chk("boost unarmed", 5'h04);
        fin.boost_undervoltage_lock = 1'b0;
        reg_en = 1'b1;
        w(8);
        t_uv(5);
        $display("arm test done");
    endtask
    task automatic t_limit;
        logic hi;
        hi = 1'b0;
        mode = 2'h1;
        fin.sourcing_current_limit = 1'b1;
        w(4);
        repeat (8) begin
            w(1);
            chk_drv("source limit", 2'b01, drv);
        end
        fin.sourcing_current_limit = 1'b0;
        fin.sinking_current_limit = 1'b1;
        // Let a new period clear the high-side truncation
        w(10);
        repeat (8) begin
            w(1);
            hi = hi | drv.high_side_on;
            chk_drv("sink limit", 2'b00, {1'b0, drv.low_side_on});
        end
        chk_drv("rearm", 2'b10, {hi, 1'b0});
        mode = 2'h2;
        w(4);
        chk("limit", 5'h04);
        fin[1:0] = 2'h0;
        $display("limit test done");
    endtask
    task automatic t_latch(input int b);
        mode = 2'h1;
        fin[b] = 1'b1;
        w(5);
        fin[b] = 1'b0;
        w(20);
        chk("latched", 5'h1A);
        mode = 2'h2;
        rst = 1'b1;
        w(3);
        rst = 1'b0;
        w(4);
        chk("cleared", 5'h04);
        $display("latch test %0d done", b);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        w(3);
        rst = 1'b0;
        w(3);
        chk("reset", 5'h04);
        t_arm;
        t_uv(6);
        t_uv(4);
        t_limit;
        t_latch(3);
        t_latch(2);
        tally_and_finish;
    end
    initial begin
        #20000;
        errors++;
        tally_and_finish;
    end
endmodule // test_power_stage_fault_manager
